// ==== hdl/cdim_digital_input_map.sv ====
`timescale 1ns/10ps
module cdim_digital_input_map
(
	// Clock and reset
	input  wire logic                                   clk,
	input  wire logic                                   rst_n,
	// Terminals: high means 24V present
	input  wire logic [cdim_pkg::NUM_IN-1:0]            terminalIn,
	input  wire logic                                   contactorSenseIn,
	// Configuration from the operator
	input  wire logic                                   configEnable,
	input  wire logic                                   cfgWrite,
	input  wire logic [1:0]                             cfgIndex,
	input  wire logic signed [cdim_pkg::VAL_W-1:0]      cfgTrueValue,
	input  wire logic signed [cdim_pkg::VAL_W-1:0]      cfgFalseValue,
	input  wire logic [cdim_pkg::SEL_W-1:0]             cfgDest,
	// Analog channel used as a logic input
	input  wire logic signed [cdim_pkg::VAL_W-1:0]      analogValue,
	// Block outputs
	output logic signed [cdim_pkg::VAL_W-1:0]           blockOutput [cdim_pkg::NUM_IN],
	output logic [cdim_pkg::NUM_IN-1:0]                 logicOutput,
	output logic [cdim_pkg::SEL_W-1:0]                  destSelect [cdim_pkg::NUM_IN],
	output logic [cdim_pkg::NUM_IN-1:0]                 input_terminal_monitor,
	output logic                                        contactor_sense_input,
	output logic                                        currentLoopEnable,
	output logic                                        analogLogic
);

	// A positive nonzero percentage is logic 1; zero and negatives are logic 0.
	function automatic logic toLogic(input logic signed [cdim_pkg::VAL_W-1:0] v);
		toLogic = (v > cdim_pkg::ZERO_VAL);
	endfunction

	function automatic logic [cdim_pkg::SEL_W-1:0] defaultDest(input int idx);
		case (idx)
			0: defaultDest = cdim_pkg::DEST_CLAMP;
			1: defaultDest = cdim_pkg::DEST_RAMPHOLD;
			2: defaultDest = cdim_pkg::DEST_ISOLATE;
			default: defaultDest = cdim_pkg::DEST_NONE;
		endcase
	endfunction

	function automatic logic signed [cdim_pkg::VAL_W-1:0] clampVal(input logic signed [cdim_pkg::VAL_W-1:0] v);
		if (v > cdim_pkg::VAL_MAX)
			clampVal = cdim_pkg::VAL_MAX;
		else if (v < cdim_pkg::VAL_MIN)
			clampVal = cdim_pkg::VAL_MIN;
		else
			clampVal = v;
	endfunction

	// The numeric and the logic output of an input share one selection.
	function automatic logic signed [cdim_pkg::VAL_W-1:0] pickValue(
		input logic                              sel,
		input logic signed [cdim_pkg::VAL_W-1:0] onTrue,
		input logic signed [cdim_pkg::VAL_W-1:0] onFalse);
		pickValue = sel ? onTrue : onFalse;
	endfunction

	logic [cdim_pkg::NUM_IN:0] syncA;
	logic [cdim_pkg::NUM_IN:0] syncB;
	logic [cdim_pkg::NUM_IN:0] syncC;
	logic [cdim_pkg::NUM_IN:0] stable;
	logic signed [cdim_pkg::VAL_W-1:0] stageTrue [cdim_pkg::NUM_IN];
	logic signed [cdim_pkg::VAL_W-1:0] stageFalse [cdim_pkg::NUM_IN];
	logic [cdim_pkg::SEL_W-1:0] stageDest [cdim_pkg::NUM_IN];
	logic signed [cdim_pkg::VAL_W-1:0] liveTrue [cdim_pkg::NUM_IN];
	logic signed [cdim_pkg::VAL_W-1:0] liveFalse [cdim_pkg::NUM_IN];
	logic configPrev;

	// Three-stage synchroniser; a level counts once the last two stages agree.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			syncA <= '0;
			syncB <= '0;
			syncC <= '0;
			stable <= '0;
		end
		else
		begin
			syncA <= {contactorSenseIn, terminalIn};
			syncB <= syncA;
			syncC <= syncB;
			for (int i = 0; i <= cdim_pkg::NUM_IN; i++)
			begin
				if (syncB[i] == syncC[i])
					stable[i] <= syncC[i];
			end
		end
	end

	// Edits land in a staging copy so a half-entered mapping never drives a destination.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < cdim_pkg::NUM_IN; i++)
			begin
				stageTrue[i] <= cdim_pkg::TRUE_RST;
				stageFalse[i] <= cdim_pkg::FALSE_RST;
				stageDest[i] <= defaultDest(i);
			end
		end
		else if (configEnable && cfgWrite)
		begin
			stageTrue[cfgIndex] <= clampVal(cfgTrueValue);
			stageFalse[cfgIndex] <= clampVal(cfgFalseValue);
			stageDest[cfgIndex] <= cfgDest;
		end
	end

	// The staged mapping takes effect when configuration enable falls.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			configPrev <= 1'b0;
			for (int i = 0; i < cdim_pkg::NUM_IN; i++)
			begin
				liveTrue[i] <= cdim_pkg::TRUE_RST;
				liveFalse[i] <= cdim_pkg::FALSE_RST;
				destSelect[i] <= defaultDest(i);
			end
		end
		else
		begin
			configPrev <= configEnable;
			if (configPrev && !configEnable)
			begin
				for (int i = 0; i < cdim_pkg::NUM_IN; i++)
				begin
					liveTrue[i] <= stageTrue[i];
					liveFalse[i] <= stageFalse[i];
					destSelect[i] <= stageDest[i];
				end
			end
		end
	end

	// Per-input value selection; swapping the two values inverts the input sense.
	genvar g;
	generate
		for (g = 0; g < cdim_pkg::NUM_IN; g++)
		begin : gen_in
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					blockOutput[g] <= cdim_pkg::FALSE_RST;
					logicOutput[g] <= 1'b0;
				end
				else
				begin
					blockOutput[g] <= pickValue(stable[g], liveTrue[g], liveFalse[g]);
					logicOutput[g] <= toLogic(pickValue(stable[g], liveTrue[g], liveFalse[g]));
				end
			end
		end
	endgenerate

	always_comb
	begin
		input_terminal_monitor = stable[cdim_pkg::NUM_IN-1:0];
		contactor_sense_input = stable[cdim_pkg::NUM_IN];
	end

	// The contact path ANDs the last two stages instead of using the agreement filter, so the loop drops on the first low stage.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			currentLoopEnable <= 1'b0;
		else
			currentLoopEnable <= syncC[cdim_pkg::NUM_IN] & syncB[cdim_pkg::NUM_IN];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			analogLogic <= 1'b0;
		else
			analogLogic <= toLogic(analogValue);
	end

	// Single-input checks first; the loop further down repeats the key ones for every input.
	AST_TRUE_VALUE: assert property (@(posedge clk) disable iff (!rst_n)
		stable[0] |=> blockOutput[0] == $past(liveTrue[0]))
		else $error("Output does not carry true-state value.");

	AST_FALSE_VALUE: assert property (@(posedge clk) disable iff (!rst_n)
		!stable[0] |=> blockOutput[0] == $past(liveFalse[0]))
		else $error("Output does not carry false-state value.");

	AST_LOGIC_MAP: assert property (@(posedge clk) disable iff (!rst_n)
		##1 logicOutput[1] == (blockOutput[1] > cdim_pkg::ZERO_VAL))
		else $error("Logic output disagrees with value.");

	AST_TERMINAL_SENSE: assert property (@(posedge clk) disable iff (!rst_n)
		(syncB[2] && syncC[2]) |=> input_terminal_monitor[2])
		else $error("High terminal not reported true.");

	AST_MONITOR: assert property (@(posedge clk) disable iff (!rst_n)
		$changed(input_terminal_monitor[0]) |-> $past(syncB[0]) == $past(syncC[0]))
		else $error("Monitor changed without agreement.");

	AST_CONTACT_OPEN: assert property (@(posedge clk) disable iff (!rst_n)
		!syncC[cdim_pkg::NUM_IN] |=> !currentLoopEnable)
		else $error("Current loop not disabled on open contact.");

	AST_CONTACT_CLOSED: assert property (@(posedge clk) disable iff (!rst_n)
		(syncB[cdim_pkg::NUM_IN] && syncC[cdim_pkg::NUM_IN]) |=> currentLoopEnable)
		else $error("Current loop not enabled on closed contact.");

	AST_CONTACT_MONITOR: assert property (@(posedge clk) disable iff (!rst_n)
		(syncB[cdim_pkg::NUM_IN] == syncC[cdim_pkg::NUM_IN])
			|=> contactor_sense_input == $past(syncC[cdim_pkg::NUM_IN]))
		else $error("Contact monitor does not follow the settled contact.");

	AST_STAGE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
		(configEnable && cfgWrite && cfgIndex == 2'h0)
			|=> stageDest[0] == $past(cfgDest))
		else $error("Destination edit not staged.");

	AST_APPLY: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(configEnable) ##1 1'b1 |-> destSelect[0] == $past(stageDest[0]))
		else $error("Mapping not applied after configuration.");

	AST_HOLD_DEST: assert property (@(posedge clk) disable iff (!rst_n)
		(configPrev == configEnable) |=> $stable(destSelect[1]))
		else $error("Destination changed outside configuration exit.");

	AST_ANALOG: assert property (@(posedge clk) disable iff (!rst_n)
		(analogValue == cdim_pkg::ZERO_VAL) |=> !analogLogic)
		else $error("Zero analog value read as logic 1.");

	AST_ANALOG_POS: assert property (@(posedge clk) disable iff (!rst_n)
		(analogValue > cdim_pkg::ZERO_VAL) |=> analogLogic)
		else $error("Positive analog value not read as logic 1.");

	AST_ANALOG_NEG: assert property (@(posedge clk) disable iff (!rst_n)
		(analogValue < cdim_pkg::ZERO_VAL) |=> !analogLogic)
		else $error("Negative analog value read as logic 1.");

	generate
		for (g = 0; g < cdim_pkg::NUM_IN; g++)
		begin : gen_chk
			AST_PICK_TRUE: assert property (@(posedge clk) disable iff (!rst_n)
				stable[g] |=> blockOutput[g] == $past(liveTrue[g]))
				else $error("Input does not deliver its true-state value.");

			AST_PICK_FALSE: assert property (@(posedge clk) disable iff (!rst_n)
				!stable[g] |=> blockOutput[g] == $past(liveFalse[g]))
				else $error("Input does not deliver its false-state value.");

			AST_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
				blockOutput[g] >= cdim_pkg::VAL_MIN && blockOutput[g] <= cdim_pkg::VAL_MAX)
				else $error("Output value outside the programmable range.");

			AST_LOGIC_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
				(blockOutput[g] <= cdim_pkg::ZERO_VAL) |-> !logicOutput[g])
				else $error("Zero value sent as logic 1.");

			AST_LOGIC_POS: assert property (@(posedge clk) disable iff (!rst_n)
				(blockOutput[g] > cdim_pkg::ZERO_VAL) |-> logicOutput[g])
				else $error("Positive value sent as logic 0.");

			AST_MONITOR_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
				(syncB[g] && syncC[g]) |=> input_terminal_monitor[g])
				else $error("High terminal not reported true.");

			AST_MONITOR_LOW: assert property (@(posedge clk) disable iff (!rst_n)
				(!syncB[g] && !syncC[g]) |=> !input_terminal_monitor[g])
				else $error("Low terminal not reported false.");

			AST_MONITOR_WAIT: assert property (@(posedge clk) disable iff (!rst_n)
				(syncB[g] != syncC[g]) |=> $stable(input_terminal_monitor[g]))
				else $error("Monitor moved before the stages agreed.");

			AST_STAGE_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
				!configEnable |=> $stable(stageDest[g]) && $stable(stageTrue[g]) && $stable(stageFalse[g]))
				else $error("Staged mapping changed while configuration was disabled.");

			AST_DEST_FROZEN: assert property (@(posedge clk) disable iff (!rst_n)
				configEnable |=> $stable(destSelect[g]))
				else $error("Live destination changed during configuration.");

			AST_LIVE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
				(configPrev == configEnable) |=> $stable(liveTrue[g]) && $stable(liveFalse[g]))
				else $error("Live values changed outside configuration exit.");

			AST_APPLY_ALL: assert property (@(posedge clk) disable iff (!rst_n)
				(configPrev && !configEnable) |=> destSelect[g] == $past(stageDest[g])
					&& liveTrue[g] == $past(stageTrue[g]) && liveFalse[g] == $past(stageFalse[g]))
				else $error("Staged mapping not copied to the live mapping.");
		end
	endgenerate
endmodule

// ==== hdl/cdim_pkg.sv ====
package cdim_pkg;
	// Values are signed hundredths of a percent: -300.00 % .. 300.00 %.
	localparam int VAL_W = 16;
	localparam int NUM_IN = 4;
	localparam int SEL_W = 10;
	localparam logic signed [15:0] VAL_MAX = 16'sh7530;
	localparam logic signed [15:0] VAL_MIN = -16'sh7530;
	localparam logic signed [15:0] TRUE_RST = 16'sh0001;
	localparam logic signed [15:0] FALSE_RST = 16'sh0000;
	localparam logic [9:0] DEST_CLAMP = 10'h05A;
	localparam logic [9:0] DEST_RAMPHOLD = 10'h076;
	localparam logic [9:0] DEST_ISOLATE = 10'h077;
	localparam logic [9:0] DEST_NONE = 10'h000;
	localparam logic signed [15:0] ZERO_VAL = 16'sh0000;
endpackage

// ==== sim/cdim_digital_input_map_bench.sv ====
`timescale 1ns/10ps
module cdim_digital_input_map_bench;
	logic              clk = 1'h0;
	logic              rst_n = 1'h0;
	logic        [3:0] terminalIn;
	logic              contactorSenseIn;
	logic              configEnable = 1'h0;
	logic              cfgWrite = 1'h0;
	logic        [1:0] cfgIndex = 2'h0;
	logic signed [15:0] cfgTrueValue = 16'h0;
	logic signed [15:0] cfgFalseValue = 16'h0;
	logic        [9:0] cfgDest = 10'h0;
	logic signed [15:0] analogValue = 16'h0;
	logic signed [15:0] blockOutput [4];
	logic        [9:0] destSelect [4];
	logic        [3:0] logicOutput;
	logic        [3:0] monitor;
	logic              contactSeen;
	logic              loopEn;
	logic              analogLogic;
	int                fails = 0;
	int                n_compared = 0;
	int                cycles = 0;
	always #5 clk = ~clk;
	cdim_switch_model m (.terminalIn(terminalIn), .contactorSenseIn(contactorSenseIn));
	cdim_digital_input_map uut (.clk(clk), .rst_n(rst_n), .terminalIn(terminalIn),
		.contactorSenseIn(contactorSenseIn), .configEnable(configEnable), .cfgWrite(cfgWrite),
		.cfgIndex(cfgIndex), .cfgTrueValue(cfgTrueValue), .cfgFalseValue(cfgFalseValue),
		.cfgDest(cfgDest), .analogValue(analogValue), .blockOutput(blockOutput),
		.logicOutput(logicOutput), .destSelect(destSelect), .input_terminal_monitor(monitor),
		.contactor_sense_input(contactSeen), .currentLoopEnable(loopEn), .analogLogic(analogLogic));
	task automatic end_sim();
		if (fails == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Staged edits must stay hidden until the enable falls.
	task automatic cfgSet(input logic [1:0] i, input logic [15:0] t, f, input logic [9:0] d, old);
		configEnable = 1'h1;
		cfgIndex = i;
		cfgTrueValue = t;
		cfgFalseValue = f;
		cfgDest = d;
		cfgWrite = 1'h1;
		cyc(1);
		cfgWrite = 1'h0;
		cyc(3);
		check("stagedDest", 16'(destSelect[i]), 16'(old));
		configEnable = 1'h0;
		cyc(3);
		check("liveDest", 16'(destSelect[i]), 16'(d));
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fails++;
			end_sim();
		end
	end
	initial
	begin
		cyc(16);
		rst_n = 1'h1;
		cyc(1);
		check("dest0", 16'(destSelect[0]), 16'(cdim_pkg::DEST_CLAMP));
		check("dest1", 16'(destSelect[1]), 16'(cdim_pkg::DEST_RAMPHOLD));
		check("dest2", 16'(destSelect[2]), 16'(cdim_pkg::DEST_ISOLATE));
		for (int v = 1; v >= 0; v--)
		begin
			m.setTerm(0, v[0]);
			cyc(6);
			check("mon0", 16'(monitor[0]), 16'(v));
			check("out0", blockOutput[0], v ? cdim_pkg::TRUE_RST : cdim_pkg::FALSE_RST);
			check("logic0", 16'(logicOutput[0]), 16'(v));
		end
		check("dest3", 16'(destSelect[3]), 16'(cdim_pkg::DEST_NONE));
		m.setTerm(2, 1'h1);
		m.setTerm(3, 1'h1);
		cyc(6);
		check("mon2", 16'(monitor[2]), 16'h0001);
		check("mon3", 16'(monitor[3]), 16'h0001);
		check("out2", blockOutput[2], cdim_pkg::TRUE_RST);
		check("logic3", 16'(logicOutput[3]), 16'h0001);
		m.setTerm(2, 1'h0);
		cyc(6);
		check("mon2low", 16'(monitor[2]), 16'h0000);
		check("out2low", blockOutput[2], cdim_pkg::FALSE_RST);
		cfgSet(2'h1, 16'h03E8, 16'h0BB8, 10'h00E, cdim_pkg::DEST_RAMPHOLD);
		cfgDest = 10'h3FF;
		cfgWrite = 1'h1;
		cyc(1);
		cfgWrite = 1'h0;
		cyc(3);
		check("lockedDest", 16'(destSelect[1]), 16'h000E);
		// A refused write must not surface when the next configuration window closes.
		configEnable = 1'h1;
		cyc(2);
		configEnable = 1'h0;
		cyc(3);
		check("refusedDest", 16'(destSelect[1]), 16'h000E);
		check("numFalse", blockOutput[1], 16'h0BB8);
		m.setTerm(1, 1'h1);
		cyc(6);
		check("numTrue", blockOutput[1], 16'h03E8);
		check("mon1", 16'(monitor[1]), 16'h0001);
		check("logic1", 16'(logicOutput[1]), 16'h0001);
		// Swapping the two values must invert the sense of the input.
		cfgSet(2'h0, 16'h0000, 16'h0001, cdim_pkg::DEST_CLAMP, cdim_pkg::DEST_CLAMP);
		check("invFalse", 16'(logicOutput[0]), 16'h0001);
		m.setTerm(0, 1'h1);
		cyc(6);
		check("invTrue", 16'(logicOutput[0]), 16'h0000);
		m.setContact(1'h0);
		cyc(4);
		check("loopOff", 16'(loopEn), 16'h0000);
		check("contact", 16'(contactSeen), 16'h0000);
		m.setContact(1'h1);
		cyc(6);
		check("loopOn", 16'(loopEn), 16'h0001);
		analogValue = 16'h0001;
		cyc(6);
		check("anaMin", 16'(analogLogic), 16'h0001);
		analogValue = 16'hFFFB;
		cyc(6);
		check("anaNeg", 16'(analogLogic), 16'h0000);
		analogValue = 16'h7530;
		cyc(6);
		check("anaMax", 16'(analogLogic), 16'h0001);
		analogValue = 16'h0000;
		cyc(6);
		check("anaZero", 16'(analogLogic), 16'h0000);
		// A second reset must bring back the default mapping and sense.
		rst_n = 1'h0;
		cyc(2);
		check("rstOut", 16'(logicOutput[0]), 16'h0000);
		rst_n = 1'h1;
		cyc(6);
		check("rstDest1", 16'(destSelect[1]), 16'(cdim_pkg::DEST_RAMPHOLD));
		check("rstTrue1", blockOutput[1], cdim_pkg::TRUE_RST);
		check("rstLogic0", 16'(logicOutput[0]), 16'h0001);
		end_sim();
	end
endmodule

// ==== sim/cdim_switch_model.sv ====
`timescale 1ns/10ps
module cdim_switch_model
(
	// Terminal levels
	output logic [3:0] terminalIn,
	output logic       contactorSenseIn
);
	initial
	begin
		terminalIn = 4'h0;
		contactorSenseIn = 1'h1;
	end
	// Level 1 stands for 24V and 0 for 0V.
	task automatic setTerm(input int i, input logic v);
		terminalIn[i] = v;
	endtask
	// The auxiliary contact is closed while the coil is energised.
	task automatic setContact(input logic v);
		contactorSenseIn = v;
	endtask
endmodule
